/* File: alf_adaptive_linefeed.v */
// Adaptive linefeed dc feed control: registers, hysteresis and closure detect
// What this block does
// R1 - State 111 floats ring side, tip active
// R2 - Five-bit current limit, 18 to 45 mA
// R3 - Limit code maps linearly, 0x0 to 0x1F
// R4 - Software encodes voltages by given formula
// R5 - Limit sets constant current threshold
// R6 - Integrated driver: 640 then 320 ohm
// R7 - Discrete driver: always 320 ohm
// R8 - On-hook target drops by current times impedance
// R9 - Low threshold: low impedance plus voltage boost
// R10 - Low impedance until limit, then constant current
// R11 - Zero boost means no voltage change
// R12 - Zero boost still switches impedance
// R13 - Current under limit returns to resistive region
// R14 - High threshold: high impedance, boost removed
// R15 - Filter current, debounce closure with thresholds
// R16 - Debounced closure sets status flag
// R17 - Decode remaining state codes as listed
// R18 - Reset leaves feed open
// R19 - Tracked voltage limited by battery minus overheads
// R20 - Thresholds are signed offsets from tracked voltage
// R21 - Shadow field shows applied feed state
// R22 - Hysteresis resets when leaving active states
`timescale 1ns/1ps
`include "alf_map.vh"

module alf_adaptive_linefeed #(
	parameter DW = 16
) (
	input  wire          clk,
	input  wire          rst,
	input  wire [7:0]    regAddr,
	input  wire [15:0]   regWrData,
	input  wire          regWrStb,
	input  wire          regRdStb,
	output reg  [15:0]   regRdData,
	input  wire [15:0]   tipRingVoltage,
	input  wire [15:0]   loopCurrentUa,
	input  wire [15:0]   batteryMagnitude,
	input  wire          sampleValid,
	output reg           tipDriveEn,
	output reg           ringDriveEn,
	output reg           ringingEn,
	output reg           reversePolarity,
	output reg           onhookTransmit,
	output reg           lowImpedance,
	output reg           constCurrentMode,
	output reg  [9:0]    sourceImpedance,
	output reg  [15:0]   currentLimitUa,
	output reg  [15:0]   openTarget,
	output reg  [15:0]   feedVoltageTarget,
	output reg           batteryRailSelect,
	output reg           loopClosureFlag
);

	// ****************************************************************
	// Synchronisers for the sense converter inputs
	// ****************************************************************
	reg [15:0] vtrMeta_r, vtr_r, iloopMeta_r, iloop_r, vbatMeta_r, vbat_r;
	reg        validMeta_r, valid_r, validDly_r;
	wire       sampleStrobe;

	// Two flops on every input from the converter
	always @(posedge clk) begin
		if (rst) begin
			{vtrMeta_r, vtr_r, iloopMeta_r, iloop_r} <= 64'h0;
			{vbatMeta_r, vbat_r} <= {2{`ALF_RST_ZERO16}};
			{validMeta_r, valid_r, validDly_r} <= 3'b000;
		end else begin
			vtrMeta_r   <= tipRingVoltage;
			vtr_r       <= vtrMeta_r;
			iloopMeta_r <= loopCurrentUa;
			iloop_r     <= iloopMeta_r;
			vbatMeta_r  <= batteryMagnitude;
			vbat_r      <= vbatMeta_r;
			validMeta_r <= sampleValid;
			valid_r     <= validMeta_r;
			validDly_r  <= valid_r;
		end
	end

	// Rising edge of the valid level marks a new sample
	assign sampleStrobe = valid_r & ~validDly_r;

	// ****************************************************************
	// Software registers
	// ****************************************************************
	reg [2:0]  feedStateCode_r;
	reg [2:0]  feedStateShadow_r;
	reg [4:0]  loopCurrentLimit_r;
	reg [14:0] openCircuitVoltage_r, commonModeOffset_r, offhookBoost_r;
	reg [14:0] headroomVoltage_r, ringingHeadroom_r;
	reg [15:0] lowDeltaThreshold_r, highDeltaThreshold_r;
	reg [15:0] closureOffhookThreshold_r, closureOnhookThreshold_r;
	reg [3:0]  closureFilterCoeff_r;
	reg [15:0] closureDebounceInterval_r;
	reg        discreteDriver_r, batteryRailSel_r;
	reg        closureEvent_r;
	wire       clrClosure;

	// Writing a one to the closure bit clears it
	assign clrClosure = regWrStb && (regAddr == `ALF_ADDR_STATUS) &&
	                    regWrData[`ALF_ST_CLOSURE];

	// Register writes; reset leaves the feed open
	always @(posedge clk) begin
		if (rst) begin
			feedStateCode_r           <= `ALF_LF_OPEN;  // see R18
			loopCurrentLimit_r        <= 5'h00;
			{openCircuitVoltage_r, commonModeOffset_r} <= 30'h0;
			{offhookBoost_r, headroomVoltage_r, ringingHeadroom_r} <= 45'h0;
			{lowDeltaThreshold_r, highDeltaThreshold_r} <= 32'h0;
			{closureOffhookThreshold_r, closureOnhookThreshold_r} <= 32'h0;
			{closureFilterCoeff_r, closureDebounceInterval_r} <= 20'h0;
			{discreteDriver_r, batteryRailSel_r} <= 2'b00;
		end else if (regWrStb) begin
			if (regAddr == `ALF_ADDR_LINEFEED)
				feedStateCode_r <= regWrData[2:0];
			else if (regAddr == `ALF_ADDR_CURRENT_LIMIT_R)
				loopCurrentLimit_r <= regWrData[4:0];  // see R2
			else if (regAddr == `ALF_ADDR_OPENV)
				openCircuitVoltage_r <= regWrData[14:0];
			else if (regAddr == `ALF_ADDR_CMOFS)
				commonModeOffset_r <= regWrData[14:0];
			else if (regAddr == `ALF_ADDR_BOOST)
				offhookBoost_r <= regWrData[14:0];
			else if (regAddr == `ALF_ADDR_LOTH)
				lowDeltaThreshold_r <= regWrData;
			else if (regAddr == `ALF_ADDR_HITH)
				highDeltaThreshold_r <= regWrData;
			else if (regAddr == `ALF_ADDR_HEADRM)
				headroomVoltage_r <= regWrData[14:0];
			else if (regAddr == `ALF_ADDR_RNGHEAD)
				ringingHeadroom_r <= regWrData[14:0];
			else if (regAddr == `ALF_ADDR_CLOFF)
				closureOffhookThreshold_r <= regWrData;
			else if (regAddr == `ALF_ADDR_CLON)
				closureOnhookThreshold_r <= regWrData;
			else if (regAddr == `ALF_ADDR_CLFILT)
				closureFilterCoeff_r <= regWrData[3:0];
			else if (regAddr == `ALF_ADDR_CLDEB)
				closureDebounceInterval_r <= regWrData;
			else if (regAddr == `ALF_ADDR_CONFIG) begin
				discreteDriver_r <= regWrData[`ALF_CFG_DISCRETE];
				batteryRailSel_r <= regWrData[`ALF_CFG_BATTERY_RAIL_SELECT];
			end
		end
	end

	// Applied state follows the written one one cycle later
	always @(posedge clk) begin
		if (rst)
			feedStateShadow_r <= `ALF_LF_OPEN;
		else
			feedStateShadow_r <= feedStateCode_r;  // see R21
	end

	// ****************************************************************
	// Tracked open-circuit voltage and thresholds
	// ****************************************************************
	reg  [16:0] overheads, demand, trackedNxt;
	reg  [16:0] loThAbs, hiThAbs;
	reg  [15:0] trackedOpen_r;

	// Battery limited open voltage, thresholds relative to it
	always @* begin
		overheads = {2'b00, headroomVoltage_r} + {2'b00, commonModeOffset_r};
		demand    = overheads + {2'b00, openCircuitVoltage_r};
		if ({1'b0, vbat_r} >= demand)
			trackedNxt = {2'b00, openCircuitVoltage_r};  // see R19
		else
			trackedNxt = {1'b0, vbat_r} - overheads;  // see R19
		loThAbs = {1'b0, trackedOpen_r} +
		          {lowDeltaThreshold_r[15], lowDeltaThreshold_r};
		hiThAbs = {1'b0, trackedOpen_r} +
		          {highDeltaThreshold_r[15], highDeltaThreshold_r}; // see R20
	end

	// Tracked value registered for read-back
	always @(posedge clk) begin
		if (rst)
			trackedOpen_r <= `ALF_RST_ZERO16;
		else if (trackedNxt[16])
			trackedOpen_r <= `ALF_RST_ZERO16;
		else
			trackedOpen_r <= trackedNxt[15:0];
	end

	// ****************************************************************
	// Adaptive hysteresis state machine
	// ****************************************************************
	localparam [1:0] ST_HIGHZ = 2'b01;
	localparam [1:0] ST_LOWZ  = 2'b10;
	reg  [1:0]  hyst_r, hyst_nxt;
	wire        activeState;
	wire [15:0] limitUa;
	wire        vtrNeg;

	// Active, on-hook transmission, tip open and ring open states keep the hysteresis alive
	assign activeState = (feedStateShadow_r == `ALF_LF_FWD) ||
	                     (feedStateShadow_r == `ALF_LF_FWDOHT) ||
	                     (feedStateShadow_r == `ALF_LF_REV) ||
	                     (feedStateShadow_r == `ALF_LF_REVOHT) ||
	                     (feedStateShadow_r == `ALF_LF_TIPOPEN) ||
	                     (feedStateShadow_r == `ALF_LF_RINGOPEN);
	// Linear limit code map
	assign limitUa = `ALF_CURRENT_LIMIT_BASE_UA + {11'h000, loopCurrentLimit_r} *
	                 `ALF_CURRENT_LIMIT_STEP_UA;  // see R3
	assign vtrNeg = lowDeltaThreshold_r[15] & loThAbs[16];

	// Threshold crossings move between impedance regions
	always @* begin
		hyst_nxt = hyst_r;
		case (hyst_r)
			ST_HIGHZ: begin
				if (sampleStrobe && {1'b0, vtr_r} <= loThAbs && !vtrNeg)
					hyst_nxt = ST_LOWZ;  // see R9
			end
			ST_LOWZ: begin
				if (sampleStrobe && {1'b0, vtr_r} >= hiThAbs)
					hyst_nxt = ST_HIGHZ;  // see R14
			end
			default: hyst_nxt = ST_HIGHZ;
		endcase
		if (!activeState)
			hyst_nxt = ST_HIGHZ;  // see R22
	end

	// Hysteresis register
	always @(posedge clk) begin
		if (rst)
			hyst_r <= ST_HIGHZ;  // see R22
		else
			hyst_r <= hyst_nxt;
	end

	// ****************************************************************
	// Loop closure filter and debounce
	// ****************************************************************
	reg [15:0] filt_r;
	reg [15:0] debCnt_r;
	reg        closed_r, closureFlag_r;
	wire [15:0] filtStep;
	wire        wantClosed;

	// First order filter, shift sets the time constant
	assign filtStep = (iloop_r >= filt_r) ?
	                  filt_r + ((iloop_r - filt_r) >> closureFilterCoeff_r) :
	                  filt_r - ((filt_r - iloop_r) >> closureFilterCoeff_r);
	assign wantClosed = closed_r ? (filt_r >= closureOnhookThreshold_r)
	                             : (filt_r >= closureOffhookThreshold_r);

	// Filter and debounce; a decision must hold for the interval
	always @(posedge clk) begin
		if (rst) begin
			filt_r       <= `ALF_RST_ZERO16;
			debCnt_r     <= `ALF_RST_ZERO16;
			closed_r       <= 1'b0;
			closureEvent_r <= 1'b0;
		end else begin
			closureEvent_r <= 1'b0;
			if (sampleStrobe) begin
				filt_r <= filtStep;  // see R15
				if (wantClosed == closed_r)
					debCnt_r <= `ALF_RST_ZERO16;
				else if (debCnt_r >= closureDebounceInterval_r) begin
					debCnt_r     <= `ALF_RST_ZERO16;
					closed_r     <= wantClosed;  // see R15
					closureEvent_r <= wantClosed;
				end else
					debCnt_r <= debCnt_r + 16'h0001;
			end
		end
	end

	// Sticky closure flag; a new event wins over a clear
	always @(posedge clk) begin
		if (rst)
			closureFlag_r <= 1'b0;
		else if (closureEvent_r)
			closureFlag_r <= 1'b1;  // see R16
		else if (clrClosure)
			closureFlag_r <= 1'b0;
	end

	// ****************************************************************
	// Feed outputs to the linefeed driver
	// ****************************************************************
	reg [15:0] boostedOpen;
	reg [31:0] dropProd;
	reg [15:0] dropMv;
	reg        lowZ;

	// Open target, impedance and resistive drop
	always @* begin
		lowZ = (hyst_r == ST_LOWZ);
		if (lowZ)
			boostedOpen = trackedOpen_r + {1'b0, offhookBoost_r}; // see R9 R11
		else
			boostedOpen = trackedOpen_r;  // see R14
		dropProd = iloop_r * (discreteDriver_r || lowZ ?
		           `ALF_Z_LOW : `ALF_Z_HIGH);  // see R6 R7 R12
		dropMv   = dropProd[25:10];
	end

	// Registered driver controls
	always @(posedge clk) begin
		if (rst) begin
			tipDriveEn        <= 1'b0;
			ringDriveEn       <= 1'b0;
			ringingEn         <= 1'b0;
			reversePolarity   <= 1'b0;
			onhookTransmit    <= 1'b0;
			lowImpedance      <= 1'b0;
			constCurrentMode  <= 1'b0;
			sourceImpedance   <= `ALF_Z_HIGH;
			currentLimitUa    <= `ALF_CURRENT_LIMIT_BASE_UA;
			openTarget        <= `ALF_RST_ZERO16;
			feedVoltageTarget <= `ALF_RST_ZERO16;
			batteryRailSelect <= 1'b0;
			loopClosureFlag   <= 1'b0;
		end else begin
			case (feedStateShadow_r)  // see R17
				`ALF_LF_OPEN:     {tipDriveEn, ringDriveEn} <= 2'b00;
				`ALF_LF_TIPOPEN:  {tipDriveEn, ringDriveEn} <= 2'b01;
				`ALF_LF_RINGOPEN: {tipDriveEn, ringDriveEn} <= 2'b10; // see R1
				default:          {tipDriveEn, ringDriveEn} <= 2'b11;
			endcase
			ringingEn       <= (feedStateShadow_r == `ALF_LF_RING);
			reversePolarity <= (feedStateShadow_r == `ALF_LF_REV) ||
			                   (feedStateShadow_r == `ALF_LF_REVOHT);
			onhookTransmit  <= (feedStateShadow_r == `ALF_LF_FWDOHT) ||
			                   (feedStateShadow_r == `ALF_LF_REVOHT);
			lowImpedance    <= lowZ;
			// In low impedance, current at limit means constant current, else resistive
			constCurrentMode <= activeState && lowZ &&
			                    (iloop_r >= limitUa);  // see R5 R10 R13
			sourceImpedance <= (discreteDriver_r || lowZ) ?
			                   `ALF_Z_LOW : `ALF_Z_HIGH;  // see R6 R7
			currentLimitUa  <= limitUa;  // see R5
			openTarget      <= boostedOpen;
			if (boostedOpen > dropMv)
				feedVoltageTarget <= boostedOpen - dropMv;  // see R8
			else
				feedVoltageTarget <= `ALF_RST_ZERO16;
			batteryRailSelect <= batteryRailSel_r;
			loopClosureFlag   <= closureFlag_r;
		end
	end

	// ****************************************************************
	// Read port, data in the cycle after the strobe
	// ****************************************************************
	always @(posedge clk) begin
		if (rst)
			regRdData <= `ALF_RST_ZERO16;
		else if (regRdStb) begin
			if (regAddr == `ALF_ADDR_LINEFEED)
				regRdData <= {9'h000, feedStateShadow_r, 1'b0, feedStateCode_r};
			else if (regAddr == `ALF_ADDR_CURRENT_LIMIT_R)
				regRdData <= {11'h000, loopCurrentLimit_r};
			else if (regAddr == `ALF_ADDR_OPENV)
				regRdData <= {1'b0, openCircuitVoltage_r};
			else if (regAddr == `ALF_ADDR_CMOFS)
				regRdData <= {1'b0, commonModeOffset_r};
			else if (regAddr == `ALF_ADDR_BOOST)
				regRdData <= {1'b0, offhookBoost_r};
			else if (regAddr == `ALF_ADDR_LOTH)
				regRdData <= lowDeltaThreshold_r;
			else if (regAddr == `ALF_ADDR_HITH)
				regRdData <= highDeltaThreshold_r;
			else if (regAddr == `ALF_ADDR_HEADRM)
				regRdData <= {1'b0, headroomVoltage_r};
			else if (regAddr == `ALF_ADDR_RNGHEAD)
				regRdData <= {1'b0, ringingHeadroom_r};
			else if (regAddr == `ALF_ADDR_TRACK)
				regRdData <= trackedOpen_r;
			else if (regAddr == `ALF_ADDR_CLOFF)
				regRdData <= closureOffhookThreshold_r;
			else if (regAddr == `ALF_ADDR_CLON)
				regRdData <= closureOnhookThreshold_r;
			else if (regAddr == `ALF_ADDR_CLFILT)
				regRdData <= {12'h000, closureFilterCoeff_r};
			else if (regAddr == `ALF_ADDR_CLDEB)
				regRdData <= closureDebounceInterval_r;
			else if (regAddr == `ALF_ADDR_STATUS)
				regRdData <= {13'h0000, constCurrentMode, lowZ, closureFlag_r};
			else if (regAddr == `ALF_ADDR_CONFIG)
				regRdData <= {14'h0000, batteryRailSel_r, discreteDriver_r};
			else if (regAddr == `ALF_ADDR_FEEDOUT)
				regRdData <= feedVoltageTarget;
			else
				regRdData <= `ALF_RST_ZERO16;
		end else
			regRdData <= `ALF_RST_ZERO16;
	end

endmodule // alf_adaptive_linefeed

/* File: alf_map.vh */
// Register offsets, field positions, reset values and codes for the feed block
`ifndef ALF_MAP_VH
`define ALF_MAP_VH
// Register addresses
`define ALF_ADDR_LINEFEED   8'h00
`define ALF_ADDR_CURRENT_LIMIT_R     8'h01
`define ALF_ADDR_OPENV      8'h02
`define ALF_ADDR_CMOFS      8'h03
`define ALF_ADDR_BOOST      8'h04
`define ALF_ADDR_LOTH       8'h05
`define ALF_ADDR_HITH       8'h06
`define ALF_ADDR_HEADRM     8'h07
`define ALF_ADDR_RNGHEAD    8'h08
`define ALF_ADDR_TRACK      8'h09
`define ALF_ADDR_CLOFF      8'h0A
`define ALF_ADDR_CLON       8'h0B
`define ALF_ADDR_CLFILT     8'h0C
`define ALF_ADDR_CLDEB      8'h0D
`define ALF_ADDR_STATUS     8'h0E
`define ALF_ADDR_CONFIG     8'h0F
`define ALF_ADDR_FEEDOUT    8'h10
// Field positions
`define ALF_LF_LSB          0
`define ALF_LFS_LSB         4
`define ALF_CFG_DISCRETE    0
`define ALF_CFG_BATTERY_RAIL_SELECT      1
`define ALF_ST_CLOSURE      0
`define ALF_ST_LOWZ         1
`define ALF_ST_CCMODE       2
// Feed state codes
`define ALF_LF_OPEN         3'h0
`define ALF_LF_FWD          3'h1
`define ALF_LF_FWDOHT       3'h2
`define ALF_LF_TIPOPEN      3'h3
`define ALF_LF_RING         3'h4
`define ALF_LF_REV          3'h5
`define ALF_LF_REVOHT       3'h6
`define ALF_LF_RINGOPEN     3'h7
// Current limit: 18 mA at code 0, step 0.875 mA, in microamps
`define ALF_CURRENT_LIMIT_BASE_UA    16'h4650
`define ALF_CURRENT_LIMIT_STEP_UA    16'h036B
// Source impedances in ohms
`define ALF_Z_HIGH          10'h280
`define ALF_Z_LOW           10'h140
// Reset values
`define ALF_RST_ZERO16      16'h0000
`endif

/* File: alf_adaptive_linefeed_sva.sv */
// Concurrent checks on the ports of the adaptive linefeed block
`timescale 1ns/1ps
`include "alf_map.vh"

module alf_adaptive_linefeed_sva (
	input wire        clk,
	input wire        rst,
	input wire [7:0]  regAddr,
	input wire [15:0] regWrData,
	input wire        regWrStb,
	input wire        regRdStb,
	input wire [15:0] regRdData,
	input wire        tipDriveEn,
	input wire        ringDriveEn,
	input wire        lowImpedance,
	input wire        constCurrentMode,
	input wire [9:0]  sourceImpedance,
	input wire [15:0] currentLimitUa,
	input wire [15:0] openTarget,
	input wire [15:0] feedVoltageTarget,
	input wire        loopClosureFlag
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// ****************************************
	// Feed state writes and lead drive
	// ****************************************
	sequence s_wr_state(logic [2:0] code);
		regWrStb && regAddr == `ALF_ADDR_LINEFEED && regWrData[2:0] == code;
	endsequence

	a_reset_defaults: assert property ($fell(rst) |-> !tipDriveEn &&
		!ringDriveEn && !lowImpedance && sourceImpedance == `ALF_Z_HIGH &&
		currentLimitUa == `ALF_CURRENT_LIMIT_BASE_UA) else $error("bad reset outputs");
	a_ring_open_leads: assert property (s_wr_state(3'h7) |->
		##3 tipDriveEn && !ringDriveEn) else $error("ring open leads");
	a_tip_open_leads: assert property (s_wr_state(3'h3) |->
		##3 !tipDriveEn && ringDriveEn) else $error("tip open leads");
	a_open_leads: assert property (s_wr_state(3'h0) |->
		##3 !tipDriveEn && !ringDriveEn) else $error("open leads");

	// ****************************************
	// Hysteresis, limit and targets
	// ****************************************
	a_lowz_impedance: assert property (lowImpedance |->
		sourceImpedance == `ALF_Z_LOW) else $error("low impedance value");
	a_impedance_legal: assert property (sourceImpedance == `ALF_Z_LOW ||
		sourceImpedance == `ALF_Z_HIGH) else $error("impedance value");
	a_cc_in_lowz: assert property (constCurrentMode |->
		lowImpedance) else $error("constant current outside low z");
	a_limit_grid: assert property (currentLimitUa >= `ALF_CURRENT_LIMIT_BASE_UA &&
		(currentLimitUa - `ALF_CURRENT_LIMIT_BASE_UA) % `ALF_CURRENT_LIMIT_STEP_UA == 16'h0000 &&
		currentLimitUa <= 16'hB045) else $error("current limit off grid");
	a_boost_up: assert property ($rose(lowImpedance) |->
		openTarget >= $past(openTarget)) else $error("boost not applied");
	a_boost_down: assert property ($fell(lowImpedance) |->
		openTarget <= $past(openTarget)) else $error("boost not removed");
	a_target_floor: assert property (feedVoltageTarget <= openTarget)
		else $error("feed target above open target");
	a_read_idle: assert property (!$past(regRdStb) |-> regRdData == 16'h0000)
		else $error("read data outside answer cycle");
	a_flag_clear: assert property ($fell(loopClosureFlag) |->
		$past(regWrStb, 2) && $past(regAddr, 2) == `ALF_ADDR_STATUS)
		else $error("closure flag dropped without clear");
endmodule // alf_adaptive_linefeed_sva

bind alf_adaptive_linefeed alf_adaptive_linefeed_sva alf_adaptive_linefeed_sva_i (
	.clk, .rst, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData,
	.tipDriveEn, .ringDriveEn, .lowImpedance, .constCurrentMode,
	.sourceImpedance, .currentLimitUa, .openTarget, .feedVoltageTarget,
	.loopClosureFlag);

/* File: alf_sense_model.sv */
// Behavioural line sense converter feeding the feed control block
`timescale 1ns/1ps

module alf_sense_model (
	input  wire        clk,
	output reg  [15:0] tipRingVoltage,
	output reg  [15:0] loopCurrentUa,
	output reg  [15:0] batteryMagnitude,
	output reg         sampleValid
);
	// Idle converter before the first conversion
	initial begin
		tipRingVoltage = 16'h0000;
		loopCurrentUa = 16'h0000;
		batteryMagnitude = 16'h0000;
		sampleValid = 1'b0;
	end

	// One conversion: settle the words, then flag them as a new set
	task sample(input [15:0] v, input [15:0] i, input [15:0] b);
		begin
			@(posedge clk);
			tipRingVoltage <= v;
			loopCurrentUa <= i;
			batteryMagnitude <= b;
			repeat (3) @(posedge clk);
			sampleValid <= 1'b1;
			repeat (2) @(posedge clk);
			sampleValid <= 1'b0;
			repeat (12) @(posedge clk);
		end
	endtask
endmodule // alf_sense_model

/* File: alf_adaptive_linefeed_tb.sv */
// Self-checking bench for the adaptive linefeed block
`timescale 1ns/1ps
`include "alf_map.vh"

module alf_adaptive_linefeed_tb;
	reg         clk, rst, regWrStb, regRdStb;
	reg  [7:0]  regAddr;
	reg  [15:0] regWrData;
	wire [15:0] regRdData, tipRingVoltage, loopCurrentUa, batteryMagnitude;
	wire [15:0] currentLimitUa, openTarget, feedVoltageTarget;
	wire [9:0]  sourceImpedance;
	wire        sampleValid, tipDriveEn, ringDriveEn, ringingEn;
	wire        reversePolarity, onhookTransmit, lowImpedance;
	wire        constCurrentMode, loopClosureFlag, batteryRailSelect;
	integer     failures, samples_checked, k;
	reg  [4:0]  leads;
	// Expected {tip, ring, ringing, reverse, onhook} per code, and care mask
	localparam [39:0] leadExp  = 40'b10000_11011_11010_00100_01000_11001_11000_00000;
	localparam [39:0] leadCare = 40'b11101_11111_11111_00101_11101_11111_11111_11111;

	alf_adaptive_linefeed alf_adaptive_linefeed_i (.clk(clk), .rst(rst),
		.regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
		.regRdStb(regRdStb), .regRdData(regRdData),
		.tipRingVoltage(tipRingVoltage), .loopCurrentUa(loopCurrentUa),
		.batteryMagnitude(batteryMagnitude), .sampleValid(sampleValid),
		.tipDriveEn(tipDriveEn), .ringDriveEn(ringDriveEn),
		.ringingEn(ringingEn), .reversePolarity(reversePolarity),
		.onhookTransmit(onhookTransmit), .lowImpedance(lowImpedance),
		.constCurrentMode(constCurrentMode), .sourceImpedance(sourceImpedance),
		.currentLimitUa(currentLimitUa), .openTarget(openTarget),
		.feedVoltageTarget(feedVoltageTarget),
		.batteryRailSelect(batteryRailSelect),
		.loopClosureFlag(loopClosureFlag));
	alf_sense_model alf_sense_model_i (.clk(clk),
		.tipRingVoltage(tipRingVoltage), .loopCurrentUa(loopCurrentUa),
		.batteryMagnitude(batteryMagnitude), .sampleValid(sampleValid));

	// ****************************************
	// Clock, bus tasks and checks
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task chk(input string n, input [15:0] e, input [15:0] g);
		begin
			samples_checked = samples_checked + 1;
			if (g !== e) begin
				failures = failures + 1;
				$display("[ERR] %s expected %h seen %h", n, e, g);
			end
		end
	endtask
	task wr(input [7:0] a, input [15:0] d);
		begin
			@(posedge clk);
			regAddr <= a;
			regWrData <= d;
			regWrStb <= 1'b1;
			@(posedge clk);
			regWrStb <= 1'b0;
		end
	endtask
	// Read data stands only in the cycle after the strobe
	task rdchk(input [7:0] a, input [15:0] e, input string n);
		begin
			@(posedge clk);
			regAddr <= a;
			regRdStb <= 1'b1;
			@(posedge clk);
			regRdStb <= 1'b0;
			#1 chk(n, e, regRdData);
		end
	endtask
	// One sample with a strong battery, then the hysteresis outputs
	task hys(input [15:0] v, i, input lz, input [9:0] z, input [15:0] ot, ft);
		begin
			alf_sense_model_i.sample(v, i, 16'h1000);
			chk("lowImpedance", {15'h0, lz}, {15'h0, lowImpedance});
			chk("sourceImpedance", {6'h0, z}, {6'h0, sourceImpedance});
			chk("openTarget", ot, openTarget);
			chk("feedVoltageTarget", ft, feedVoltageTarget);
		end
	endtask
	task results;
		begin
			$display("checks %0d mismatches %0d", samples_checked, failures);
			if (failures == 0 && samples_checked > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	// Cuts a hang short
	initial begin
		repeat (60000) @(posedge clk);
		failures = failures + 1;
		results;
	end

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		failures = 0;
		samples_checked = 0;
		rst = 1'b1;
		{regWrStb, regRdStb, regAddr, regWrData} = 26'h0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		#1 chk("sourceImpedance", 16'h0280, {6'h0, sourceImpedance});
		chk("currentLimitUa", `ALF_CURRENT_LIMIT_BASE_UA, currentLimitUa);
		rdchk(`ALF_ADDR_LINEFEED, 16'h0000, "linefeed");
		$display("test reset done");
		for (k = 0; k < 8; k = k + 1) begin
			wr(`ALF_ADDR_LINEFEED, k[15:0]);
			repeat (3) @(posedge clk);
			leads = {tipDriveEn, ringDriveEn, ringingEn, reversePolarity,
				onhookTransmit};
			chk("leads", {11'h0, leadExp[k*5 +: 5]},
				{11'h0, leads & leadCare[k*5 +: 5]});
			rdchk(`ALF_ADDR_LINEFEED, {9'h0, k[2:0], 1'b0, k[2:0]}, "shadow");
		end
		$display("test states done");
		for (k = 0; k < 32; k = k + 1) begin
			wr(`ALF_ADDR_CURRENT_LIMIT_R, k[15:0]);
			repeat (3) @(posedge clk);
			chk("currentLimitUa", `ALF_CURRENT_LIMIT_BASE_UA +
				`ALF_CURRENT_LIMIT_STEP_UA * k[15:0], currentLimitUa);
			rdchk(`ALF_ADDR_CURRENT_LIMIT_R, k[15:0], "limit");
		end
		wr(`ALF_ADDR_CURRENT_LIMIT_R, 16'h0000);
		for (k = 2; k <= 8; k = k + 1) begin
			wr(k[7:0], 16'hFFFF);
			rdchk(k[7:0], (k == 5 || k == 6) ? 16'hFFFF : 16'h7FFF, "register");
		end
		wr(8'h20, 16'hFFFF);
		rdchk(8'h20, 16'h0000, "unmapped");
		wr(`ALF_ADDR_CONFIG, 16'h0002);
		repeat (2) @(posedge clk);
		chk("batteryRailSelect", 16'h0001, {15'h0, batteryRailSelect});
		rdchk(`ALF_ADDR_CONFIG, 16'h0002, "config");
		$display("test registers done");
		// Voltages below are already in register units
		wr(`ALF_ADDR_OPENV, 16'h03E8);
		wr(`ALF_ADDR_CMOFS, 16'h0032);
		wr(`ALF_ADDR_HEADRM, 16'h0064);
		wr(`ALF_ADDR_BOOST, 16'h0064);
		wr(`ALF_ADDR_LOTH, 16'hFF38);
		wr(`ALF_ADDR_HITH, 16'h0032);
		wr(`ALF_ADDR_CONFIG, 16'h0000);
		wr(`ALF_ADDR_LINEFEED, 16'h0001);
		hys(16'h03E8, 16'h0000, 1'b0, 10'h280, 16'h03E8, 16'h03E8);
		hys(16'h0384, 16'h0400, 1'b0, 10'h280, 16'h03E8, 16'h0168);
		hys(16'h0320, 16'h0400, 1'b1, 10'h140, 16'h044C, 16'h030C);
		hys(16'h0320, 16'h4E20, 1'b1, 10'h140, 16'h044C, 16'h0000);
		chk("constCurrentMode", 16'h0001, {15'h0, constCurrentMode});
		hys(16'h0384, 16'h0400, 1'b1, 10'h140, 16'h044C, 16'h030C);
		chk("constCurrentMode", 16'h0000, {15'h0, constCurrentMode});
		hys(16'h041A, 16'h0000, 1'b0, 10'h280, 16'h03E8, 16'h03E8);
		wr(`ALF_ADDR_BOOST, 16'h0000);
		hys(16'h0320, 16'h0000, 1'b1, 10'h140, 16'h03E8, 16'h03E8);
		hys(16'h041A, 16'h0000, 1'b0, 10'h280, 16'h03E8, 16'h03E8);
		wr(`ALF_ADDR_CONFIG, 16'h0001);
		hys(16'h03E8, 16'h0000, 1'b0, 10'h140, 16'h03E8, 16'h03E8);
		hys(16'h0320, 16'h0000, 1'b1, 10'h140, 16'h03E8, 16'h03E8);
		wr(`ALF_ADDR_LINEFEED, 16'h0000);
		alf_sense_model_i.sample(16'h0320, 16'h0000, 16'h1000);
		chk("lowImpedance", 16'h0000, {15'h0, lowImpedance});
		wr(`ALF_ADDR_CONFIG, 16'h0000);
		$display("test hysteresis done");
		wr(`ALF_ADDR_LINEFEED, 16'h0001);
		alf_sense_model_i.sample(16'h03E8, 16'h0000, 16'h1000);
		rdchk(`ALF_ADDR_TRACK, 16'h03E8, "tracked");
		alf_sense_model_i.sample(16'h03E8, 16'h0000, 16'h0400);
		rdchk(`ALF_ADDR_TRACK, 16'h036A, "tracked");
		chk("openTarget", 16'h036A, openTarget);
		alf_sense_model_i.sample(16'h02C0, 16'h0000, 16'h0400);
		chk("lowImpedance", 16'h0000, {15'h0, lowImpedance});
		alf_sense_model_i.sample(16'h02A2, 16'h0000, 16'h0400);
		chk("lowImpedance", 16'h0001, {15'h0, lowImpedance});
		alf_sense_model_i.sample(16'h03E8, 16'h0000, 16'h0400);
		$display("test tracking done");
		wr(`ALF_ADDR_CLOFF, 16'h4E20);
		wr(`ALF_ADDR_CLON, 16'h2710);
		wr(`ALF_ADDR_CLFILT, 16'h0000);
		wr(`ALF_ADDR_CLDEB, 16'h0002);
		for (k = 0; k < 4; k = k + 1)
			alf_sense_model_i.sample(16'h03E8, 16'h0000, 16'h0400);
		wr(`ALF_ADDR_STATUS, 16'h0001);
		for (k = 0; k < 3; k = k + 1)
			alf_sense_model_i.sample(16'h03E8, 16'h61A8, 16'h0400);
		chk("loopClosureFlag", 16'h0000, {15'h0, loopClosureFlag});
		alf_sense_model_i.sample(16'h03E8, 16'h61A8, 16'h0400);
		chk("loopClosureFlag", 16'h0001, {15'h0, loopClosureFlag});
		rdchk(`ALF_ADDR_STATUS, 16'h0001, "status");
		for (k = 0; k < 4; k = k + 1)
			alf_sense_model_i.sample(16'h03E8, 16'h0000, 16'h0400);
		wr(`ALF_ADDR_STATUS, 16'h0001);
		repeat (3) @(posedge clk);
		chk("loopClosureFlag", 16'h0000, {15'h0, loopClosureFlag});
		rdchk(`ALF_ADDR_STATUS, 16'h0000, "status");
		$display("test closure done");
		results;
	end
endmodule // alf_adaptive_linefeed_tb
